// ==== design/uart_pkg.sv ====
// Purpose: shared constants and types for one serial channel core
// Assumes: 10 MHz system clock, AHB-Lite register access
// Notes: register index n sits at byte address 4*n
package uart_pkg;
   localparam logic [2:0] IDX_DATA = 3'h0;
   localparam logic [2:0] IDX_IER = 3'h1;
   localparam logic [2:0] IDX_IIR = 3'h2;
   localparam logic [2:0] IDX_LCR = 3'h3;
   localparam logic [2:0] IDX_MCR = 3'h4;
   localparam logic [2:0] IDX_LSR = 3'h5;
   localparam logic [2:0] IDX_MSR = 3'h6;
   localparam logic [2:0] IDX_SCR = 3'h7;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // crystal 24 MHz over 13, made from the 10 MHz clock by a phase accumulator
   localparam int XTAL_KHZ = 24000;
   localparam int PRE_DIV = 13;
   localparam int CLK_KHZ = 10000;
   localparam logic [17:0] ACC_STEP = 18'(XTAL_KHZ);
   localparam logic [17:0] ACC_MOD = 18'(PRE_DIV * CLK_KHZ);
   localparam logic [15:0] DIV_ZERO_N = 16'h0003;
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0e;
   // start + five data + one stop
   localparam logic [3:0] BASE_BITS = 4'h7;
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LINE = 4'h6;
   localparam logic [3:0] IID_RDA = 4'h4;
   localparam logic [3:0] IID_TMO = 4'hc;
   localparam logic [3:0] IID_THR = 4'h2;
   localparam logic [3:0] IID_MODEM = 4'h0;

   typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DATA = 2'b10} bus_state_t;

   typedef struct packed {
      logic carrier_detect_in_n;
      logic ring_indicator_in_n;
      logic data_set_ready_in_n;
      logic clear_to_send_in_n;
   } modem_t;

   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
      logic [7:0] data;
   } rx_entry_t;

   typedef struct packed {
      bus_state_t bus;
      logic [2:0] idx;
      logic wr;
      logic hit;
      logic [31:0] rdata;
      logic [7:0] interrupt_enable_bits;
      logic [7:0] lcr;
      logic [7:0] line_output_control;
      logic [7:0] scratch_byte;
      logic [7:0] dll;
      logic [7:0] dlm;
      logic fifoEn;
      logic [1:0] trig;
      rx_entry_t [15:0] rxMem;
      logic [3:0] rxRd;
      logic [3:0] rxWr;
      logic [4:0] rxCnt;
      logic topSeen;
      logic [15:0][7:0] txMem;
      logic [3:0] txRd;
      logic [3:0] txWr;
      logic [4:0] txCnt;
      logic oe;
      logic [2:0] lsrErr;
      logic [3:0] delta;
      modem_t m1;
      modem_t m2;
      logic [3:0] statQ;
      logic [17:0] acc;
      logic refLvl;
      logic [15:0] baudCnt;
      logic baudOut;
      logic [9:0] toCnt;
      logic toPend;
      logic twoSeen;
      logic [7:0] txDly;
      logic threQ;
      logic thrInt;
   } state_t;

   localparam state_t STATE_RST = '{bus: BUS_IDLE, threQ: 1'b1,
      m1: modem_t'(4'hf), m2: modem_t'(4'hf), default: '0};
endpackage

// ==== design/uart_baud_fifo_interrupt.sv ====
// Purpose: baud generator, modem status, scratch, FIFO interrupts
// Assumes: serial shift logic sits outside and uses the ports below
// Notes: every bus transfer takes one wait state
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module uart_baud_fifo_interrupt (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // modem pins, active low except loopbackOn
   input wire uart_pkg::modem_t modemIn_n,
   output logic terminalReadyN,
   output logic request_send_ctl,
   output logic user_output_one,
   output logic user_output_two,
   output logic loopbackOn,
   // receive shift logic
   input wire logic rxCharValid,
   input wire logic [7:0] rxCharData,
   input wire logic [2:0] rxCharErr,
   // transmit shift logic
   output logic txValid,
   output logic [7:0] txData,
   input wire logic txTake,
   input wire logic txShiftEmpty,
   // clocks and interrupt
   output logic baudClk,
   output logic rclkTick,
   output logic serialIrq
);
   uart_pkg::state_t q, d;
   uart_pkg::rx_entry_t rxTop;
   logic [17:0] accSum;
   logic refTick, rclk, act, rdOp, wrOp, divisor_access_bit;
   logic rdRbr, wrThr, rxPush, rxFull, divWr, lineInt, rdaInt, toInt;
   logic [3:0] stat, iid, bitsPerChar;
   logic [4:0] trigLvl, rxCap;
   logic [7:0] lsrVal, msrVal, rdVal;
   logic [9:0] tmoLimit;
   logic [15:0] errVec, divQ;

   // fractional divider: 24/130 of clock edges give a reference tick
   assign accSum = q.acc + uart_pkg::ACC_STEP;
   assign refTick = accSum >= uart_pkg::ACC_MOD;
   assign rclk = refTick && q.baudCnt == 16'h0000;
   assign act = q.bus == uart_pkg::BUS_DATA && q.hit;
   assign rdOp = act && !q.wr;
   assign wrOp = act && q.wr;
   assign divisor_access_bit = q.lcr[7];
   assign rdRbr = rdOp && q.idx == uart_pkg::IDX_DATA && !divisor_access_bit;
   assign wrThr = wrOp && q.idx == uart_pkg::IDX_DATA && !divisor_access_bit;
   assign divWr = wrOp && divisor_access_bit && (q.idx == uart_pkg::IDX_DATA ||
      q.idx == uart_pkg::IDX_IER);
   // non-FIFO mode behaves as a one-deep holding register
   assign rxCap = q.fifoEn ? uart_pkg::FIFO_DEPTH : 5'h01;
   assign rxFull = q.rxCnt == rxCap;
   assign rxPush = rxCharValid && !rxFull;
   assign rxTop = q.rxMem[q.rxRd];
   assign bitsPerChar = uart_pkg::BASE_BITS + {2'b00, q.lcr[1:0]} +
      {3'b000, q.lcr[3]} + {3'b000, q.lcr[2]};
   assign tmoLimit = {bitsPerChar, 6'h00};
   assign divQ = {q.dlm, q.dll} == 16'h0000 ? uart_pkg::DIV_ZERO_N :
      {q.dlm, q.dll};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_err
         assign errVec[gi] = ({1'b0, 4'(4'(gi) - q.rxRd)} < q.rxCnt) &&
            (|q.rxMem[gi][10:8]);
      end
   endgenerate

   always_comb
   begin
      case (q.trig)
         2'b00: trigLvl = uart_pkg::TRIG_L0;
         2'b01: trigLvl = uart_pkg::TRIG_L1;
         2'b10: trigLvl = uart_pkg::TRIG_L2;
         default: trigLvl = uart_pkg::TRIG_L3;
      endcase
   end

   assign stat = q.line_output_control[4] ? {q.line_output_control[3], q.line_output_control[2], q.line_output_control[0], q.line_output_control[1]} :
      ~q.m2;
   assign msrVal = {stat, q.delta};
   assign lsrVal = {q.fifoEn && |errVec, q.threQ && txShiftEmpty, q.threQ,
      q.lsrErr, q.oe, q.rxCnt != 5'h00};
   assign lineInt = q.interrupt_enable_bits[2] && (q.oe || |q.lsrErr);
   assign rdaInt = q.interrupt_enable_bits[0] && (q.fifoEn ? q.rxCnt >= trigLvl :
      q.rxCnt != 5'h00);
   assign toInt = q.interrupt_enable_bits[0] && q.fifoEn && q.toPend;

   always_comb
   begin
      if (lineInt)
         iid = uart_pkg::IID_LINE;
      else if (rdaInt)
         iid = uart_pkg::IID_RDA;
      else if (toInt)
         iid = uart_pkg::IID_TMO;
      else if (q.interrupt_enable_bits[1] && q.thrInt)
         iid = uart_pkg::IID_THR;
      else if (q.interrupt_enable_bits[3] && |q.delta)
         iid = uart_pkg::IID_MODEM;
      else
         iid = uart_pkg::IID_NONE;
   end

   always_comb
   begin
      if (!q.hit)
         rdVal = 8'h00;
      else if (q.idx == uart_pkg::IDX_DATA)
         rdVal = divisor_access_bit ? q.dll : rxTop.data;
      else if (q.idx == uart_pkg::IDX_IER)
         rdVal = divisor_access_bit ? q.dlm : q.interrupt_enable_bits;
      else if (q.idx == uart_pkg::IDX_IIR)
         rdVal = {q.fifoEn, q.fifoEn, 2'b00, iid};
      else if (q.idx == uart_pkg::IDX_LCR)
         rdVal = q.lcr;
      else if (q.idx == uart_pkg::IDX_MCR)
         rdVal = q.line_output_control;
      else if (q.idx == uart_pkg::IDX_LSR)
         rdVal = lsrVal;
      else if (q.idx == uart_pkg::IDX_MSR)
         rdVal = msrVal;
      else
         rdVal = q.scratch_byte;
   end

   always_comb
   begin
      logic fifoChg, rxClr, txClr, txPush, txPop, rxPop;
      logic [4:0] txCap;
      logic [7:0] dlyLen;
      logic [15:0] divN;
      fifoChg = 1'b0;
      rxClr = 1'b0;
      txClr = 1'b0;
      rxPop = 1'b0;
      txPush = 1'b0;
      txPop = 1'b0;
      txCap = 5'h00;
      dlyLen = 8'h00;
      divN = 16'h0000;
      d = q;
      d.m1 = modemIn_n;
      d.m2 = q.m1;
      case (q.bus)
         uart_pkg::BUS_IDLE:
            if (hsel && htrans[1] && hready)
            begin
               d.bus = uart_pkg::BUS_DATA;
               d.idx = haddr[4:2];
               d.wr = hwrite;
               d.hit = haddr[31:5] == 27'h0 && haddr[1:0] == 2'b00 &&
                  hsize == uart_pkg::HSIZE_WORD;
            end
         uart_pkg::BUS_DATA:
         begin
            d.bus = uart_pkg::BUS_IDLE;
            d.rdata = {24'h000000, rdVal};
         end
         default: d.bus = uart_pkg::BUS_IDLE;
      endcase
      if (wrOp)
      begin
         if (q.idx == uart_pkg::IDX_DATA)
         begin
            if (divisor_access_bit)
               d.dll = hwdata[7:0];
         end
         else if (q.idx == uart_pkg::IDX_IER)
         begin
            if (divisor_access_bit)
               d.dlm = hwdata[7:0];
            else
               d.interrupt_enable_bits = {4'h0, hwdata[3:0]};
         end
         else if (q.idx == uart_pkg::IDX_IIR)
         begin
            fifoChg = hwdata[0] != q.fifoEn;
            rxClr = hwdata[1] || fifoChg;
            txClr = hwdata[2] || fifoChg;
            d.fifoEn = hwdata[0];
            d.trig = hwdata[7:6];
         end
         else if (q.idx == uart_pkg::IDX_LCR)
            d.lcr = hwdata[7:0];
         else if (q.idx == uart_pkg::IDX_MCR)
            d.line_output_control = {3'h0, hwdata[4:0]};
         else if (q.idx == uart_pkg::IDX_SCR)
            d.scratch_byte = hwdata[7:0];
      end
      // receive FIFO
      rxPop = rdRbr && q.rxCnt != 5'h00;
      if (rxPush)
      begin
         d.rxMem[q.rxWr] = {rxCharErr, rxCharData};
         d.rxWr = q.rxWr + 4'h1;
      end
      if (rxPop)
      begin
         d.rxRd = q.rxRd + 4'h1;
         d.topSeen = 1'b0;
      end
      d.rxCnt = q.rxCnt + {4'h0, rxPush} - {4'h0, rxPop};
      // errors latch once when a character reaches the top
      if (rdOp && q.idx == uart_pkg::IDX_LSR)
      begin
         d.oe = 1'b0;
         d.lsrErr = 3'h0;
      end
      if (rxCharValid && rxFull)
         d.oe = 1'b1;
      if (q.rxCnt != 5'h00 && !q.topSeen && !rxPop)
      begin
         d.lsrErr = d.lsrErr | {rxTop.brk, rxTop.fe, rxTop.pe};
         d.topSeen = 1'b1;
      end
      if (rxClr)
      begin
         d.rxRd = 4'h0;
         d.rxWr = 4'h0;
         d.rxCnt = 5'h00;
         d.topSeen = 1'b0;
      end
      // transmit FIFO
      txCap = q.fifoEn ? uart_pkg::FIFO_DEPTH : 5'h01;
      txPush = wrThr && q.txCnt != txCap;
      txPop = txTake && q.txCnt != 5'h00;
      if (txPush)
      begin
         d.txMem[q.txWr] = hwdata[7:0];
         d.txWr = q.txWr + 4'h1;
      end
      if (txPop)
         d.txRd = q.txRd + 4'h1;
      d.txCnt = q.txCnt + {4'h0, txPush} - {4'h0, txPop};
      if (txClr)
      begin
         d.txRd = 4'h0;
         d.txWr = 4'h0;
         d.txCnt = 5'h00;
      end
      // modem deltas, a new change wins over the clearing read
      if (rdOp && q.idx == uart_pkg::IDX_MSR)
         d.delta = 4'h0;
      d.statQ = stat;
      d.delta = d.delta | {stat[3] ^ q.statQ[3], q.statQ[2] & ~stat[2],
         stat[1] ^ q.statQ[1], stat[0] ^ q.statQ[0]};
      // baud generator on reference ticks
      d.acc = refTick ? accSum - uart_pkg::ACC_MOD : accSum;
      // reference level is high for one clock per reference period
      d.refLvl = refTick;
      divN = {d.dlm, d.dll};
      if (divN == 16'h0000)
         divN = uart_pkg::DIV_ZERO_N;
      if (divWr)
         d.baudCnt = divN - 16'h0001;
      else if (refTick)
         d.baudCnt = q.baudCnt == 16'h0000 ? divN - 16'h0001 :
            q.baudCnt - 16'h0001;
      if (divN == 16'h0001)
         d.baudOut = ~d.refLvl;
      else if (divN == 16'h0002)
         d.baudOut = d.baudCnt[0];
      else
         d.baudOut = d.baudCnt >= 16'h0002;
      // receive timeout, counted on the receive clock
      if (q.rxCnt == 5'h00 || rxClr || rdRbr)
      begin
         d.toCnt = 10'h000;
         d.toPend = 1'b0;
      end
      else if (rxPush && !q.toPend)
         d.toCnt = 10'h000;
      else
      begin
         if (rclk && q.toCnt != tmoLimit)
            d.toCnt = q.toCnt + 10'h001;
         if (q.toCnt == tmoLimit)
            d.toPend = 1'b1;
      end
      // transmit empty, held back in FIFO mode unless two bytes were queued
      dlyLen = q.fifoEn && !q.twoSeen ?
         {bitsPerChar - 4'h1, 4'h0} : 8'h00;
      if (q.txCnt >= 5'h02)
         d.twoSeen = 1'b1;
      if (q.txCnt != 5'h00)
      begin
         d.threQ = 1'b0;
         d.txDly = dlyLen;
      end
      else if (!q.threQ)
      begin
         if (q.txDly == 8'h00)
         begin
            d.threQ = 1'b1;
            d.twoSeen = 1'b0;
         end
         else if (rclk)
            d.txDly = q.txDly - 8'h01;
      end
      if (wrThr || (rdOp && q.idx == uart_pkg::IDX_IIR &&
         iid == uart_pkg::IID_THR))
         d.thrInt = 1'b0;
      if ((d.threQ && !q.threQ) || fifoChg)
         d.thrInt = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         q <= uart_pkg::STATE_RST;
      else
         q <= d;
   end

   assign hreadyout = q.bus != uart_pkg::BUS_DATA;
   assign hrdata = q.rdata;
   assign hresp = 1'b0;
   // control pins forced inactive high in loopback
   assign terminalReadyN = q.line_output_control[4] || !q.line_output_control[0];
   assign request_send_ctl = q.line_output_control[4] || !q.line_output_control[1];
   assign user_output_one = q.line_output_control[4] || !q.line_output_control[2];
   assign user_output_two = q.line_output_control[4] || !q.line_output_control[3];
   assign loopbackOn = q.line_output_control[4];
   assign txValid = q.txCnt != 5'h00;
   assign txData = q.txMem[q.txRd];
   assign baudClk = q.baudOut;
   assign rclkTick = rclk;
   assign serialIrq = !iid[0] && q.line_output_control[3];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_msr;
      !q.line_output_control[4] && !$past(q.line_output_control[4]) |->
         msrVal[7:4] == ~$past(modemIn_n, 2);
   endproperty
   a_msr: assert property (p_msr) else $error("modem status wrong");
   property p_scr;
      wrOp && q.idx == uart_pkg::IDX_SCR |=> q.scratch_byte == $past(hwdata[7:0]);
   endproperty
   a_scr: assert property (p_scr) else $error("scratch lost");
   property p_reload;
      divWr |=> q.baudCnt == divQ - 16'h0001;
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");
   property p_low;
      !divWr && refTick && divQ >= 16'h0003 && q.baudCnt == 16'h0002
         |=> !q.baudOut;
   endproperty
   a_low: assert property (p_low) else $error("baud low phase");
   property p_high;
      !divWr && refTick && divQ >= 16'h0003 && q.baudCnt == 16'h0000
         |=> q.baudOut;
   endproperty
   a_high: assert property (p_high) else $error("baud high phase");
   property p_ref;
      refTick |=> !refTick [*4];
   endproperty
   a_ref: assert property (p_ref) else $error("reference too fast");
   property p_rda;
      rdaInt && !lineInt |-> iid == uart_pkg::IID_RDA;
   endproperty
   a_rda: assert property (p_rda) else $error("rda not shown");
   property p_prio;
      lineInt |-> iid == uart_pkg::IID_LINE;
   endproperty
   a_prio: assert property (p_prio) else $error("line priority");
   property p_dr;
      rxPush |=> lsrVal[0];
   endproperty
   a_dr: assert property (p_dr) else $error("data ready missed");
   property p_tmoclr;
      rdRbr && q.toPend |=> !q.toPend;
   endproperty
   a_tmoclr: assert property (p_tmoclr) else $error("timeout held");
   property p_thrclr;
      wrThr && q.threQ |=> !q.thrInt;
   endproperty
   a_thrclr: assert property (p_thrclr) else $error("thr int held");
   property p_fcr;
      wrOp && q.idx == uart_pkg::IDX_IIR && hwdata[0] != q.fifoEn
         |=> q.thrInt;
   endproperty
   a_fcr: assert property (p_fcr) else $error("no thr int");
   property p_poll;
      !q.interrupt_enable_bits[0] |-> iid != uart_pkg::IID_RDA && iid != uart_pkg::IID_TMO;
   endproperty
   a_poll: assert property (p_poll) else $error("polled report");

   c_tmo: cover property (!q.toPend ##1 q.toPend);
   c_thr: cover property (iid == uart_pkg::IID_THR);
   c_ovr: cover property (rxCharValid && rxFull);
   c_line: cover property (lineInt && rdaInt);
endmodule // uart_baud_fifo_interrupt

// ==== dv/serial_peer_model.sv ====
// Purpose: far-side serial peer: modem pins, received chars, tx drain
// Assumes: the bench calls its tasks just after a rising edge
// Notes: released data lines show the inverse of the last char
`timescale 1ns/10ps
module serial_peer_model (
   // clock
   input wire logic clock,
   // bench control
   input wire logic stall,
   // toward the block
   output uart_pkg::modem_t modemIn_n,
   output logic rxCharValid,
   output logic [7:0] rxCharData,
   output logic [2:0] rxCharErr,
   output logic txTake,
   output logic txShiftEmpty,
   // from the block
   input wire logic txValid
);
   initial
   begin
      modemIn_n = 4'hf;
      rxCharValid = 1'b0;
      rxCharData = 8'h00;
      rxCharErr = 3'h0;
   end
   // valid stays up between chars, so it never toggles twice in one step
   task automatic send(input logic [7:0] d, input logic [2:0] e);
      rxCharValid <= 1'b1;
      rxCharData <= d;
      rxCharErr <= e;
      @(posedge clock);
   endtask
   task automatic idle();
      rxCharValid <= 1'b0;
      rxCharData <= ~rxCharData;
      rxCharErr <= ~rxCharErr;
   endtask
   task automatic pins(input logic [3:0] v);
      modemIn_n <= v;
   endtask
   // one pop every other cycle at most, stalls on request
   initial txTake = 1'b0;
   initial txShiftEmpty = 1'b1;
   always @(posedge clock)
   begin
      txTake <= txValid && !stall && !txTake;
      txShiftEmpty <= !txValid && !txTake;
   end
endmodule // serial_peer_model

// ==== dv/test_uart_baud_fifo_interrupt.sv ====
// Purpose: self-checking bench for the serial channel core
// Assumes: one AHB-Lite master, peer model on the line side
// Notes: read results are queued by the driver, checked by a monitor
`timescale 1ns/10ps
`define CHK(a, b) \
   begin \
      num_checks++; \
      if ((a) !== (b)) \
      begin \
         errors++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); \
      end \
   end
module test_uart_baud_fifo_interrupt;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0, stall = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, m, x;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = uart_pkg::HSIZE_WORD;
   logic hreadyout, hresp, rxCharValid, txValid, txTake, txShiftEmpty;
   logic baudClk, rclkTick, serialIrq, terminalReadyN, request_send_ctl;
   logic user_output_one, user_output_two, loopbackOn;
   uart_pkg::modem_t modemIn_n;
   logic [7:0] rxCharData, txData, r, t, d[4];
   logic [2:0] rxCharErr;
   logic [31:0] expQ[$], mskQ[$];
   logic bPrev;
   logic [7:0] txQ[$];
   int errors = 0, num_checks = 0, n, e, b;
   int dvs[4] = '{0, 3, 2, 1};

   uart_baud_fifo_interrupt i_dut (.clock(clock), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .modemIn_n(modemIn_n), .terminalReadyN(terminalReadyN),
      .request_send_ctl(request_send_ctl),
      .user_output_one(user_output_one), .user_output_two(user_output_two),
      .loopbackOn(loopbackOn), .rxCharValid(rxCharValid),
      .rxCharData(rxCharData), .rxCharErr(rxCharErr), .txValid(txValid),
      .txData(txData), .txTake(txTake), .txShiftEmpty(txShiftEmpty),
      .baudClk(baudClk), .rclkTick(rclkTick), .serialIrq(serialIrq));

   serial_peer_model i_peer (.clock(clock), .stall(stall),
      .modemIn_n(modemIn_n), .rxCharValid(rxCharValid),
      .rxCharData(rxCharData), .rxCharErr(rxCharErr), .txTake(txTake),
      .txShiftEmpty(txShiftEmpty), .txValid(txValid));

   initial forever #50 clock = ~clock;

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hready is the slave's own hreadyout; wait as long as it asks
   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] wd, input logic [31:0] ex, input logic [31:0] mk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      if (!w)
      begin
         expQ.push_back(ex & mk);
         mskQ.push_back(mk);
      end
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask
   task automatic wr(input logic [2:0] i, input logic [7:0] v);
      bus(1'b1, {27'h0, i, 2'b00}, {24'h0, v}, '0, '0);
   endtask
   task automatic rd(input logic [2:0] i, input logic [7:0] v,
      input logic [7:0] k = 8'hff);
      bus(1'b0, {27'h0, i, 2'b00}, '0, {24'h0, v}, {24'hffffff, k});
   endtask

   always @(posedge clock)
   begin
      if (rdPend && hreadyout)
      begin
         m = mskQ.pop_front();
         x = expQ.pop_front();
         `CHK(hrdata & m, x)
         `CHK(hresp, 1'b0)
      end
      if (hreadyout)
         rdPend <= hsel && htrans[1] && !hwrite;
      if (txTake && txValid)
      begin
         t = txQ.pop_front();
         `CHK(txData, t)
      end
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      errors++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(32'hd589a640));
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(uart_pkg::IDX_LSR, 8'h60);
      bus(1'b0, 32'h20, '0, '0, '1);
      r = 8'($urandom);
      wr(uart_pkg::IDX_SCR, r);
      rd(uart_pkg::IDX_SCR, r);
      rd(uart_pkg::IDX_MCR, 8'h00);
      r = 8'($urandom);
      i_peer.pins(r[3:0]);
      repeat (4) @(posedge clock);
      rd(uart_pkg::IDX_MSR, {~r[3:0], 4'h0}, 8'hf0);
      wr(uart_pkg::IDX_MCR, {4'h1, r[3:0]});
      rd(uart_pkg::IDX_MSR, {r[3:2], r[0], r[1], 4'h0}, 8'hf0);
      `CHK({terminalReadyN, request_send_ctl, user_output_one,
         user_output_two, loopbackOn}, 5'h1f)
      wr(uart_pkg::IDX_MCR, 8'h08);
      `CHK({terminalReadyN, request_send_ctl, user_output_one,
         user_output_two, loopbackOn}, 5'b11100)
      foreach (dvs[k])
      begin
         wr(uart_pkg::IDX_LCR, 8'h80);
         wr(uart_pkg::IDX_DATA, 8'(dvs[k]));
         wr(uart_pkg::IDX_IER, 8'h00);
         rd(uart_pkg::IDX_DATA, 8'(dvs[k]));
         wr(uart_pkg::IDX_LCR, 8'h00);
         n = 0;
         b = 0;
         bPrev = baudClk;
         repeat (6500)
         begin
            @(posedge clock);
            n += int'(rclkTick);
            b += int'(baudClk && !bPrev);
            bPrev = baudClk;
         end
         e = 1200 / (dvs[k] == 0 ? 3 : dvs[k]);
         `CHK(n >= e - 1 && n <= e + 1, 1'b1)
         `CHK(b >= e - 1 && b <= e + 1, 1'b1)
      end
      // fifo on, trigger four, line status and data interrupts
      wr(uart_pkg::IDX_IIR, 8'h41);
      wr(uart_pkg::IDX_IER, 8'h05);
      foreach (d[k])
      begin
         d[k] = 8'($urandom);
         i_peer.send(d[k], 3'(k == 0));
      end
      i_peer.idle();
      @(posedge clock);
      rd(uart_pkg::IDX_IIR, 8'hc6);
      `CHK(serialIrq, 1'b1)
      rd(uart_pkg::IDX_LSR, 8'h05, 8'h05);
      rd(uart_pkg::IDX_IIR, 8'hc4);
      rd(uart_pkg::IDX_DATA, d[0]);
      rd(uart_pkg::IDX_IIR, 8'hc1);
      repeat (1500) @(posedge clock);
      rd(uart_pkg::IDX_IIR, 8'hc1);
      repeat (1500) @(posedge clock);
      rd(uart_pkg::IDX_IIR, 8'hcc);
      rd(uart_pkg::IDX_DATA, d[1]);
      rd(uart_pkg::IDX_IIR, 8'hc1);
      // polled: interrupts off, fifo keeps buffering
      wr(uart_pkg::IDX_IER, 8'h00);
      i_peer.send(d[0], 3'h0);
      i_peer.send(d[1], 3'h0);
      i_peer.idle();
      @(posedge clock);
      rd(uart_pkg::IDX_IIR, 8'hc1);
      `CHK(serialIrq, 1'b0)
      for (int k = 2; k < 6; k++)
         rd(uart_pkg::IDX_DATA, d[k % 4]);
      rd(uart_pkg::IDX_LSR, 8'h00, 8'h01);
      // transmit side, peer stalled while the fifo fills
      wr(uart_pkg::IDX_IER, 8'h02);
      wr(uart_pkg::IDX_IIR, 8'h40);
      wr(uart_pkg::IDX_IIR, 8'h41);
      rd(uart_pkg::IDX_IIR, 8'hc2);
      rd(uart_pkg::IDX_IIR, 8'hc1);
      stall <= 1'b1;
      repeat (2)
      begin
         r = 8'($urandom);
         txQ.push_back(r);
         wr(uart_pkg::IDX_DATA, r);
      end
      rd(uart_pkg::IDX_LSR, 8'h00, 8'h60);
      stall <= 1'b0;
      repeat (20) @(posedge clock);
      rd(uart_pkg::IDX_IIR, 8'hc2);
      rd(uart_pkg::IDX_LSR, 8'h60, 8'h60);
      report_and_stop();
   end
endmodule // test_uart_baud_fifo_interrupt
